//--- design/rspc_pkg.sv
// Package of constants and types for the reset strap and pull-up control.
package rspc_pkg;

    // ========================================================================
    // Host index/data port addresses
    // ========================================================================
    localparam logic [15:0] RSPC_IDX_PRI = 16'h03E0;
    localparam logic [15:0] RSPC_DAT_PRI = 16'h03E1;
    localparam logic [15:0] RSPC_IDX_SEC = 16'h03E2;
    localparam logic [15:0] RSPC_DAT_SEC = 16'h03E3;

    // ========================================================================
    // Slot pull-up control register
    // ========================================================================
    localparam logic [5:0] RSPC_PULLUP_OFS = 6'h3F;
    localparam logic [7:0] RSPC_PULLUP_RST = 8'h00;
    localparam int         RSPC_CDVS_OFF_BIT = 5;
    localparam int         RSPC_BVDRDY_BIT   = 4;
    localparam int         RSPC_INPWAIT_BIT  = 3;

    // ========================================================================
    // Index bits that select the slot quarter
    // ========================================================================
    localparam int RSPC_SLOT_MSB = 7;
    localparam int RSPC_SLOT_LSB = 6;

    // ========================================================================
    // Strap decodes
    // ========================================================================
    typedef enum logic [1:0] {
        RSPC_SLOT_A = 2'b00,
        RSPC_SLOT_B = 2'b01,
        RSPC_SLOT_C = 2'b10,
        RSPC_SLOT_D = 2'b11
    } rspc_slot_t;

    typedef enum logic [1:0] {
        RSPC_TST_NAND  = 2'b00,
        RSPC_TST_HILO  = 2'b01,
        RSPC_TST_LOHI  = 2'b10,
        RSPC_TST_TRIST = 2'b11
    } rspc_test_t;

endpackage : rspc_pkg

//--- design/rspc_strap_cap.sv
// Strap pin synchronisers and reset-time strap capture.
`timescale 1ns/100ps
module rspc_strap_cap
    import rspc_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  srst_i,
    // Pin levels: {slot_supply_3v3_enable, slot_supply_5v_enable, vpp_follow, vpp_program}
    input  wire logic  [3:0] pins_i,
    input  wire logic  ale_i,
    // Captured settings
    rspc_strap_if.cap  strap
);

    // ========================================================================
    // Three-stage synchronisers
    // ========================================================================
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] sync3_ff;
    logic [4:0] stable_ff;
    wire  [4:0] agree_w = ~(sync2_ff ^ sync3_ff);
    wire  [4:0] nxt_stable = (agree_w & sync3_ff) | (~agree_w & stable_ff);

    always_ff @(posedge clk_sys_i) begin
        sync1_ff  <= {ale_i, pins_i};
        sync2_ff  <= sync1_ff;
        sync3_ff  <= sync2_ff;
        stable_ff <= nxt_stable;
    end

    // ========================================================================
    // Capture while reset is active, hold afterwards
    // ========================================================================
    logic [4:0] cap_ff;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cap_ff <= nxt_stable;
        end
    end

    assign strap.port_sec  = cap_ff[2];
    assign strap.slot      = rspc_slot_t'({~cap_ff[1], ~cap_ff[0]});
    assign strap.test_en   = cap_ff[3];
    assign strap.test_fn   = rspc_test_t'({~cap_ff[1], ~cap_ff[0]});
    assign strap.core_sel  = cap_ff[4];
    assign strap.pins_sync = stable_ff[3:0];

    core_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !srst_i |=> $stable(cap_ff[4]))
        else $error("Core supply setting changed outside reset.");

endmodule : rspc_strap_cap

//--- design/rspc_strap_if.sv
// Interface carrying captured strap settings between the two modules.
`timescale 1ns/100ps
interface rspc_strap_if;
    import rspc_pkg::*;

    rspc_slot_t slot;
    rspc_test_t test_fn;
    logic       test_en;
    logic       port_sec;
    logic       core_sel;
    logic [3:0] pins_sync;

    modport cap (
        output slot,
        output test_fn,
        output test_en,
        output port_sec,
        output core_sel,
        output pins_sync
    );

    modport use_side (
        input slot,
        input test_fn,
        input test_en,
        input port_sec,
        input core_sel,
        input pins_sync
    );
endinterface : rspc_strap_if

//--- design/rspc_top.sv
// Reset strap capture, power pin control and slot pull-up control.
`timescale 1ns/100ps

// Operation
// - Capture strap pin levels during reset; they configure ports, slot, test.
// - During reset both programming-voltage enables are pulled high.
// - During reset the 5V and 3.3V supply enables are never driven high.
// - Slot_supply_5v_enable high at reset selects secondary index/data ports.
// - Data-port access accepted only when index lies in the slot quarter.
// - Slot A no strap, B program low, C follow low, D both low.
// - Card-detect and voltage-sense pull-ups on unless control bit 5 set.
// - Battery-detect and ready pull-ups follow control bit 4.
// - Input-acknowledge and wait pull-ups follow control bit 3.
// - Pull-ups on programming-voltage pins are active only during reset.
// - Slot_supply_3v3_enable high at reset enters test mode, else normal operation.
// - In test mode straps pick NAND, alternating, inverted or tristate.
// - Core supply level is learnt from ALE at reset and held.
module rspc_top
    import rspc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // Host index/data port access
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_claim_o,
    // Requested power pin levels from the slot logic
    input  wire logic        pwr_slot_supply_5v_enable_req_i,
    input  wire logic        pwr_slot_supply_3v3_enable_req_i,
    input  wire logic        pwr_vpp_prog_req_i,
    input  wire logic        pwr_vpp_follow_req_i,
    // Power control pins, also straps
    input  wire logic        slot_supply_5v_enable_i,
    output logic             slot_supply_5v_enable_o,
    output logic             slot_supply_5v_enable_oe_o,
    input  wire logic        slot_supply_3v3_enable_i,
    output logic             slot_supply_3v3_enable_o,
    output logic             slot_supply_3v3_enable_oe_o,
    input  wire logic        vpp_program_enable_i,
    output logic             vpp_program_enable_o,
    output logic             vpp_program_enable_oe_o,
    input  wire logic        vpp_follow_supply_enable_i,
    output logic             vpp_follow_supply_enable_o,
    output logic             vpp_follow_supply_enable_oe_o,
    // Core supply strap
    input  wire logic        ale_i,
    // Pull-up enables and strap status
    output logic             vpp_pullup_en_o,
    output logic             cd_vs_pullup_en_o,
    output logic             bvd_rdy_pullup_en_o,
    output logic             inpack_wait_pullup_en_o,
    output logic             core_supply_sel_o,
    output logic             test_mode_o,
    output logic             test_nand_o
);

    // ========================================================================
    // Strap capture
    // ========================================================================
    rspc_strap_if strap ();

    rspc_strap_cap u_cap (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .pins_i    ({slot_supply_3v3_enable_i, slot_supply_5v_enable_i,
                     vpp_follow_supply_enable_i, vpp_program_enable_i}),
        .ale_i     (ale_i),
        .strap     (strap.cap)
    );

    // ========================================================================
    // Index/data port decode
    // ========================================================================
    logic [7:0] idx_ff;
    logic [7:0] ctrl_ff;

    function automatic logic in_quarter(input logic [7:0] idx,
                                        input logic [1:0] slot);
        in_quarter = (idx[RSPC_SLOT_MSB:RSPC_SLOT_LSB] == slot);
    endfunction : in_quarter

    wire [15:0] idx_port_w = strap.port_sec ? RSPC_IDX_SEC : RSPC_IDX_PRI;
    wire [15:0] dat_port_w = strap.port_sec ? RSPC_DAT_SEC : RSPC_DAT_PRI;
    wire        hit_idx_w  = (io_addr_i == idx_port_w);
    wire        hit_dat_w  = (io_addr_i == dat_port_w);
    // index must fall in slot quarter
    wire        idx_ok_w   = in_quarter(idx_ff, strap.slot);
    wire        dat_acc_w  = hit_dat_w && idx_ok_w && (io_wr_i || io_rd_i);
    wire        idx_acc_w  = hit_idx_w && (io_wr_i || io_rd_i);
    wire        reg_sel_w  = idx_ff[5:0] == RSPC_PULLUP_OFS;

    wire [7:0]  nxt_idx    = (hit_idx_w && io_wr_i) ? io_wdata_i : idx_ff;
    wire [7:0]  nxt_ctrl   = (dat_acc_w && io_wr_i && reg_sel_w) ?
                             io_wdata_i : ctrl_ff;
    wire [7:0]  nxt_rdata  = (idx_acc_w && io_rd_i) ? idx_ff :
                             (dat_acc_w && io_rd_i && reg_sel_w) ? ctrl_ff :
                             8'h00;
    wire        nxt_claim  = idx_acc_w || dat_acc_w;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            idx_ff     <= 8'h00;
            ctrl_ff    <= RSPC_PULLUP_RST;
            io_rdata_o <= 8'h00;
            io_claim_o <= 1'b0;
        end else begin
            idx_ff     <= nxt_idx;
            ctrl_ff    <= nxt_ctrl;
            io_rdata_o <= nxt_rdata;
            io_claim_o <= nxt_claim;
        end
    end

    // ========================================================================
    // Pull-up enables
    // ========================================================================
    // card-detect pull-ups off by bit
    wire nxt_cdvs  = ~ctrl_ff[RSPC_CDVS_OFF_BIT];
    wire nxt_bvd   = ctrl_ff[RSPC_BVDRDY_BIT];
    wire nxt_inpw  = ctrl_ff[RSPC_INPWAIT_BIT];

    always_ff @(posedge clk_sys_i) begin
        cd_vs_pullup_en_o       <= nxt_cdvs;
        bvd_rdy_pullup_en_o     <= nxt_bvd;
        inpack_wait_pullup_en_o <= nxt_inpw;
    end

    always_ff @(posedge clk_sys_i) begin
        vpp_pullup_en_o <= srst_i;
    end

    // ========================================================================
    // Power pin drive
    // ========================================================================
    // Order of the packed pin vectors: {slot_supply_3v3_enable, slot_supply_5v_enable, vpp_follow, vpp_prog}.
    logic [3:0] nxt_pin_o;
    logic [3:0] nxt_pin_oe;
    wire  [3:0] req_w = {pwr_slot_supply_3v3_enable_req_i, pwr_slot_supply_5v_enable_req_i,
                         pwr_vpp_follow_req_i, pwr_vpp_prog_req_i};

    always_comb begin
        nxt_pin_o  = req_w;
        nxt_pin_oe = 4'hF;
        if (strap.test_en) begin
            case (strap.test_fn)
                RSPC_TST_HILO: begin
                    nxt_pin_o = 4'hA;
                end
                RSPC_TST_LOHI: begin
                    nxt_pin_o = 4'h5;
                end
                RSPC_TST_TRIST: begin
                    nxt_pin_o  = 4'h0;
                    nxt_pin_oe = 4'h0;
                end
                default: begin
                    nxt_pin_o = req_w;
                end
            endcase
        end
    end

    // Pins are released during reset so the straps can be sensed; the vpp
    // pins sit high on their pull-ups and the supply pins are never driven
    // high, so no card voltage is switched on by the reset itself.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            vpp_program_enable_o          <= 1'b1;
            vpp_program_enable_oe_o       <= 1'b0;
            vpp_follow_supply_enable_o    <= 1'b1;
            vpp_follow_supply_enable_oe_o <= 1'b0;
            slot_supply_5v_enable_o       <= 1'b0;
            slot_supply_5v_enable_oe_o    <= 1'b0;
            slot_supply_3v3_enable_o      <= 1'b0;
            slot_supply_3v3_enable_oe_o   <= 1'b0;
        end else begin
            vpp_program_enable_o          <= nxt_pin_o[0];
            vpp_program_enable_oe_o       <= nxt_pin_oe[0];
            vpp_follow_supply_enable_o    <= nxt_pin_o[1];
            vpp_follow_supply_enable_oe_o <= nxt_pin_oe[1];
            slot_supply_5v_enable_o       <= nxt_pin_o[2];
            slot_supply_5v_enable_oe_o    <= nxt_pin_oe[2];
            slot_supply_3v3_enable_o      <= nxt_pin_o[3];
            slot_supply_3v3_enable_oe_o   <= nxt_pin_oe[3];
        end
    end

    // ========================================================================
    // Strap status outputs
    // ========================================================================
    wire nxt_nand = strap.test_en && (strap.test_fn == RSPC_TST_NAND) &&
                    ~&strap.pins_sync;

    always_ff @(posedge clk_sys_i) begin
        core_supply_sel_o <= strap.core_sel;
        test_mode_o       <= strap.test_en;
        test_nand_o       <= nxt_nand;
    end

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    vpp_pull_rst_a: assert property (
        $fell(srst_i) |-> vpp_pullup_en_o ##1 !vpp_pullup_en_o)
        else $error("Vpp pull-up not confined to reset.");

    vpp_high_rst_a: assert property (
        $fell(srst_i) |-> vpp_program_enable_o && !vpp_program_enable_oe_o
                      && vpp_follow_supply_enable_o
                      && !vpp_follow_supply_enable_oe_o)
        else $error("Vpp pins not released high during reset.");

    supply_low_rst_a: assert property (
        $fell(srst_i) |-> !slot_supply_5v_enable_oe_o
                      && !slot_supply_3v3_enable_oe_o)
        else $error("Supply pins driven during reset.");

    port_pair_sel_a: assert property (
        (io_wr_i || io_rd_i) && io_addr_i[15:2] == RSPC_IDX_PRI[15:2]
        && io_addr_i[1] != strap.port_sec |=> !io_claim_o)
        else $error("Port of the unselected pair was claimed.");

    slot_range_a: assert property (
        io_wr_i && hit_dat_w && !idx_ok_w |=> $stable(ctrl_ff)
                                             && !io_claim_o)
        else $error("Data access accepted outside slot quarter.");

    cdvs_pullup_a: assert property (
        ctrl_ff[RSPC_CDVS_OFF_BIT] ##1 ctrl_ff[RSPC_CDVS_OFF_BIT]
        |-> !cd_vs_pullup_en_o)
        else $error("Card-detect pull-up active while disabled.");

    bvd_pullup_a: assert property (
        $rose(ctrl_ff[RSPC_BVDRDY_BIT]) |=> bvd_rdy_pullup_en_o)
        else $error("Battery pull-up did not follow control bit.");

    inpw_pullup_a: assert property (
        $fell(ctrl_ff[RSPC_INPWAIT_BIT]) |=> !inpack_wait_pullup_en_o)
        else $error("Wait pull-up did not follow control bit.");

    strap_hold_a: assert property (
        !$past(srst_i) |-> $stable(strap.slot) && $stable(strap.port_sec)
                         && $stable(strap.test_en))
        else $error("Captured strap changed outside reset.");

    // ========================================================================
    // Power pin, test pattern, host port and core status checks
    // ========================================================================
    // Each attempt below samples reset in its antecedent. The disable
    // condition sees the live reset, so the releasing edge would otherwise
    // start an attempt against outputs still held in their reset state.
    norm_follow_a: assert property (
        !srst_i && !strap.test_en
        |=> slot_supply_5v_enable_oe_o && vpp_program_enable_oe_o
            && slot_supply_5v_enable_o == $past(pwr_slot_supply_5v_enable_req_i)
            && vpp_program_enable_o == $past(pwr_vpp_prog_req_i))
        else $error("Power pins did not follow requests.");

    tristate_off_a: assert property (
        !srst_i && strap.test_en && strap.test_fn == RSPC_TST_TRIST
        |=> !slot_supply_5v_enable_oe_o && !slot_supply_3v3_enable_oe_o
            && !vpp_program_enable_oe_o && !vpp_follow_supply_enable_oe_o)
        else $error("Outputs driven in tristate test.");

    hilo_pattern_a: assert property (
        !srst_i && strap.test_en && strap.test_fn == RSPC_TST_HILO
        |=> slot_supply_3v3_enable_o && !slot_supply_5v_enable_o
            && vpp_follow_supply_enable_o && !vpp_program_enable_o)
        else $error("Alternating high/low pattern wrong.");

    lohi_pattern_a: assert property (
        !srst_i && strap.test_en && strap.test_fn == RSPC_TST_LOHI
        |=> !slot_supply_3v3_enable_o && slot_supply_5v_enable_o
            && !vpp_follow_supply_enable_o && vpp_program_enable_o)
        else $error("Alternating low/high pattern wrong.");

    nand_high_a: assert property (
        !srst_i && strap.test_en && strap.test_fn == RSPC_TST_NAND
        && &strap.pins_sync |=> !test_nand_o)
        else $error("NAND test output high with all inputs high.");

    idx_claim_a: assert property (
        !srst_i && (io_wr_i || io_rd_i) && hit_idx_w |=> io_claim_o)
        else $error("Index port access not claimed.");

    rd_refused_a: assert property (
        !srst_i && io_rd_i && hit_dat_w && !idx_ok_w
        |=> !io_claim_o && io_rdata_o == 8'h00)
        else $error("Data read answered outside slot quarter.");

    core_out_a: assert property (
        !srst_i |=> core_supply_sel_o == $past(strap.core_sel))
        else $error("Core supply status does not match capture.");

endmodule : rspc_top

//--- verification/rspc_board_model.sv
// Board strap resistors and power switch inputs on the shared power pins.
`timescale 1ns/100ps
module rspc_board_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Straps fitted: {slot_supply_3v3_enable high, slot_supply_5v_enable high, follow low, program low}
    input  wire logic [3:0] strap_i,
    // Device side, order {slot_supply_3v3_enable, slot_supply_5v_enable, follow, program}
    input  wire logic [3:0] drv_i,
    input  wire logic [3:0] oe_i,
    input  wire logic       vpp_pullup_en_i,
    // Resolved pin levels
    output logic      [3:0] pin_o
);
    logic [3:0] last_ff;
    logic [3:0] idle;

    // ====================================================================
    // Pin resolution
    // ====================================================================
    // The switch inputs carry pull-downs, so an unstrapped supply pin idles
    // low. An unstrapped Vpp pin with its pull-up off floats, so it shows
    // the inverse of its last level rather than a tidy value.
    assign idle[3:2] = strap_i[3:2];
    assign idle[1:0] = ~strap_i[1:0] & ({2{vpp_pullup_en_i}} | ~last_ff[1:0]);
    assign pin_o     = (oe_i & drv_i) | (~oe_i & idle);

    always_ff @(posedge clk_sys_i) begin
        last_ff <= pin_o;
    end
endmodule : rspc_board_model

//--- verification/test_reset_strap_and_pullup_control.sv
// Self-checking bench for the reset strap and pull-up control block.
`timescale 1ns/100ps
module test_reset_strap_and_pullup_control;
    import rspc_pkg::*;
    // In test rows the slot field holds the expected test function.
    typedef struct {
        logic [3:0] strap;
        logic       ale;
        logic [1:0] slot;
        logic       sec;
        logic       tst;
    } rspc_row_t;

    rspc_row_t rows [12] = '{
        '{4'h0, 1'b0, 2'd0, 1'b0, 1'b0}, '{4'h1, 1'b1, 2'd1, 1'b0, 1'b0},
        '{4'h2, 1'b0, 2'd2, 1'b0, 1'b0}, '{4'h3, 1'b1, 2'd3, 1'b0, 1'b0},
        '{4'h4, 1'b1, 2'd0, 1'b1, 1'b0}, '{4'h5, 1'b0, 2'd1, 1'b1, 1'b0},
        '{4'h6, 1'b1, 2'd2, 1'b1, 1'b0}, '{4'h7, 1'b0, 2'd3, 1'b1, 1'b0},
        '{4'h8, 1'b0, 2'd0, 1'b0, 1'b1}, '{4'h9, 1'b1, 2'd1, 1'b0, 1'b1},
        '{4'hA, 1'b0, 2'd2, 1'b0, 1'b1}, '{4'hF, 1'b1, 2'd3, 1'b1, 1'b1}};

    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00;
    logic [3:0]  req = 4'h0;
    logic [3:0]  strap = 4'h0;
    logic        ale_i = 1'b0;
    logic [7:0]  io_rdata_o;
    logic        io_claim_o;
    logic [3:0]  pin, drv, oe;
    logic        vpp_pu, cd_vs, bvd, inp, core, tmode, tnand;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    rspc_top dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .io_claim_o(io_claim_o),
        .pwr_slot_supply_5v_enable_req_i(req[2]), .pwr_slot_supply_3v3_enable_req_i(req[3]),
        .pwr_vpp_prog_req_i(req[0]), .pwr_vpp_follow_req_i(req[1]),
        .slot_supply_5v_enable_i(pin[2]), .slot_supply_5v_enable_o(drv[2]),
        .slot_supply_5v_enable_oe_o(oe[2]),
        .slot_supply_3v3_enable_i(pin[3]), .slot_supply_3v3_enable_o(drv[3]),
        .slot_supply_3v3_enable_oe_o(oe[3]),
        .vpp_program_enable_i(pin[0]), .vpp_program_enable_o(drv[0]),
        .vpp_program_enable_oe_o(oe[0]),
        .vpp_follow_supply_enable_i(pin[1]),
        .vpp_follow_supply_enable_o(drv[1]),
        .vpp_follow_supply_enable_oe_o(oe[1]),
        .ale_i(ale_i), .vpp_pullup_en_o(vpp_pu), .cd_vs_pullup_en_o(cd_vs),
        .bvd_rdy_pullup_en_o(bvd), .inpack_wait_pullup_en_o(inp),
        .core_supply_sel_o(core), .test_mode_o(tmode), .test_nand_o(tnand));

    rspc_board_model board (.clk_sys_i(clk_sys_i), .strap_i(strap),
        .drv_i(drv), .oe_i(oe), .vpp_pullup_en_i(vpp_pu), .pin_o(pin));

    // ====================================================================
    // Tasks
    // ====================================================================
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic io(input logic rd, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= ~rd;
        io_rd_i <= rd;
        @(posedge clk_sys_i);
        io_wr_i <= 1'b0;
        io_rd_i <= 1'b0;
        #1;
    endtask : io

    task automatic do_reset(input rspc_row_t r);
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        strap <= r.strap;
        ale_i <= r.ale;
        req <= 4'hF;
        repeat (11) @(posedge clk_sys_i);
        #1;
        check("vpp_pullup", vpp_pu, 1'b1);
        check("oe_reset", oe, 4'h0);
        check("drv_reset", drv, 4'h3);
        check("vpp_pins", pin[1:0], {6'h00, ~r.strap[1:0]});
        @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("vpp_pullup_off", vpp_pu, 1'b0);
        check("test_mode", tmode, r.tst);
        check("core_sel", core, r.ale);
        check("cd_vs_rst", cd_vs, 1'b1);
        check("bvd_rst", bvd, 1'b0);
        check("inp_rst", inp, 1'b0);
    endtask : do_reset

    task automatic normal_row(input rspc_row_t r);
        logic [15:0] ix;
        logic [15:0] dx;
        logic [7:0]  b;
        logic [7:0]  d;
        ix = r.sec ? RSPC_IDX_SEC : RSPC_IDX_PRI;
        dx = r.sec ? RSPC_DAT_SEC : RSPC_DAT_PRI;
        b = {r.slot, 6'h3F};
        d = r.sec ? 8'h10 : 8'h28;
        check("pin_drv", drv & oe, 4'hF);
        io(1'b0, ix, b);
        check("idx_claim", io_claim_o, 1'b1);
        io(1'b0, dx, d);
        check("dat_claim", io_claim_o, 1'b1);
        io(1'b1, dx, 8'h00);
        check("rd_claim", io_claim_o, 1'b1);
        check("rd_data", io_rdata_o, d);
        io(1'b0, ix, b ^ 8'h40);
        io(1'b0, dx, d ^ 8'h38);
        check("other_claim", io_claim_o, 1'b0);
        io(1'b1, dx, 8'h00);
        check("other_rd_claim", io_claim_o, 1'b0);
        check("other_rdata", io_rdata_o, 8'h00);
        io(1'b1, ix ^ 16'h0002, 8'h00);
        check("pair_claim", io_claim_o, 1'b0);
        io(1'b1, ix, 8'h00);
        check("idx_read", io_rdata_o, b ^ 8'h40);
        check("cd_vs", cd_vs, !d[5]);
        check("bvd_rdy", bvd, d[4]);
        check("inp_wait", inp, d[3]);
        check("mode_held", {core, tmode}, {r.ale, 1'b0});
    endtask : normal_row

    task automatic test_row(input rspc_row_t r);
        logic [3:0] eo;
        eo = (r.slot == RSPC_TST_TRIST) ? 4'h0 : 4'hF;
        @(posedge clk_sys_i);
        req <= 4'h0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        check("test_oe", oe, eo);
        check("test_drv", drv & eo, (r.slot == RSPC_TST_HILO) ? 4'hA :
              (r.slot == RSPC_TST_LOHI) ? 4'h5 : 4'h0);
        if (r.slot == RSPC_TST_NAND) begin
            check("nand_lo", tnand, 1'b1);
            @(posedge clk_sys_i);
            req <= 4'hF;
            repeat (6) @(posedge clk_sys_i);
            #1;
            check("nand_hi", tnand, 1'b0);
        end
    endtask : test_row

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // ====================================================================
    // Sequence
    // ====================================================================
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        for (int i = 0; i < 12; i++) begin
            do_reset(rows[i]);
            if (rows[i].tst) begin
                test_row(rows[i]);
            end else begin
                normal_row(rows[i]);
            end
            $display("row %0d done", i);
        end
        // In-quarter index other than the register: claimed, nothing stored.
        do_reset(rows[0]);
        io(1'b0, RSPC_IDX_PRI, 8'h05);
        io(1'b0, RSPC_DAT_PRI, 8'hFF);
        check("near_claim", io_claim_o, 1'b1);
        io(1'b1, RSPC_DAT_PRI, 8'h00);
        check("near_rdata", io_rdata_o, 8'h00);
        io(1'b0, RSPC_IDX_PRI, 8'h40);
        io(1'b0, RSPC_DAT_PRI, 8'hFF);
        check("edge_claim", io_claim_o, 1'b0);
        check("cd_vs_kept", cd_vs, 1'b1);
        // Set then clear the wait pull-up bit; the output lags one cycle.
        io(1'b0, RSPC_IDX_PRI, 8'h3F);
        io(1'b0, RSPC_DAT_PRI, 8'h08);
        io(1'b0, RSPC_DAT_PRI, 8'h00);
        check("inp_set", inp, 1'b1);
        io(1'b1, RSPC_DAT_PRI, 8'h00);
        check("ctrl_clear", io_rdata_o, 8'h00);
        check("inp_clear", inp, 1'b0);
        $display("quarter edge test done");
        stop_test();
    end
endmodule : test_reset_strap_and_pullup_control
